//--- hdl/adc_ctrl_defines.svh
// Constants of the serial conversion control block
// How it works
// - A rising conversion_trigger starts a conversion.
// - Trigger still high after conversion ends puts the device to sleep.
// - Trigger low enables the serial result output.
// - The result leaves serially on serial_result_out.
// - Two-channel version takes its configuration word on serial_config_in.
// - All serial transfers are timed by the host shift clock.
// - Conversion ends within 3.2 us, 3.3 us for the extended grade.
// - New result bit follows a falling shift clock; old bit held until then.
// - Trigger rising puts the result output into high impedance.
// - Configuration input is sampled on rising shift clock edges.
// - Two configuration bits captured after trigger falls; later bits ignored.
// - First bit: 1 single-ended, 0 differential; second selects channel or polarity.
// - After the full result, further shift clocks give zeros.
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

`define RESULT_BITS       16
`define CFG_BITS          2
`define CFG_RESET         2'h2
`define CLK_PERIOD_NS     10.0
`define CONVERSION_TRIGGER_TIME_STD_US  3.2
`define CONVERSION_TRIGGER_TIME_EXT_US  3.3
`define NS_PER_US         1000.0
`define ROUND_GUARD       1.0e-6
`define BUF_DEPTH         2
`define PIN_TRIG          0
`define PIN_SCK           1
`define PIN_CFG           2
`define PIN_COUNT         3

`endif

//--- hdl/adc_ctrl_pkg.sv
// Types shared by the serial conversion control block
package adc_ctrl_pkg;

    // Gray order: idle, convert, sleep, transfer
    typedef enum logic [1:0]
    {
        ST_IDLE     = 2'h0,
        ST_CONVERT  = 2'h1,
        ST_SLEEP    = 2'h3,
        ST_TRANSFER = 2'h2
    } ctrl_state_t;

endpackage

//--- hdl/adc_serial_ctrl.sv
// Conversion sequencing and serial transfer of a sampling converter
`timescale 1ns/10ps
`include "adc_ctrl_defines.svh"
module adc_serial_ctrl
    import adc_ctrl_pkg::*;
#(
    parameter int RESULT_W    = `RESULT_BITS,
    parameter bit TWO_CHANNEL = 1'b1,
    parameter bit EXT_GRADE   = 1'b0
)(
    input  wire logic                ref_clk_i,
    input  wire logic                rst_i,
    input  wire logic                conversion_trigger_i,
    input  wire logic                shift_clk_i,
    input  wire logic                serial_config_in_i,
    output logic                     serial_result_out_o,
    output logic                     serial_result_oe_n_o,
    output logic                     conversion_trigger_start_o,
    output logic                     sleep_o,
    output logic                     single_or_differential_select_o,
    output logic                     odd_or_sign_o,
    input  wire logic                result_valid_i,
    input  wire logic [RESULT_W-1:0] result_data_i,
    output logic                     result_ready_o
);

    // =========================================================
    // Timing constants
    localparam real CONVERSION_TRIGGER_US  = EXT_GRADE ? `CONVERSION_TRIGGER_TIME_EXT_US : `CONVERSION_TRIGGER_TIME_STD_US;
    localparam int  CONVERSION_TRIGGER_RAW = $rtoi(CONVERSION_TRIGGER_US * `NS_PER_US / `CLK_PERIOD_NS + `ROUND_GUARD);
    localparam int  CONVERSION_TRIGGER_CYC = (CONVERSION_TRIGGER_RAW < 1) ? 1 : CONVERSION_TRIGGER_RAW;
    localparam int  CNT_W    = $clog2(CONVERSION_TRIGGER_CYC + 1);
    localparam int  SH_W     = $clog2(RESULT_W + 1);
    localparam int  CONVERSION_TRIGGER_BOUND = CONVERSION_TRIGGER_CYC;
    localparam logic [CNT_W-1:0] CONVERSION_TRIGGER_LOAD = CNT_W'(CONVERSION_TRIGGER_CYC - 1);
    localparam logic [SH_W-1:0]  SH_FULL   = SH_W'(RESULT_W);
    localparam logic [1:0]       CFG_FULL  = 2'(`CFG_BITS);

    if (RESULT_W < 2)
    begin : g_chk
        $error("adc_serial_ctrl result width must be at least 2");
    end

    // =========================================================
    // Pin synchronisers
    logic [`PIN_COUNT-1:0] pin_lvl;
    logic [`PIN_COUNT-1:0] pin_rise;
    logic [`PIN_COUNT-1:0] pin_fall;
    logic                  trig_lvl;
    logic                  trig_rise;
    logic                  trig_fall;
    logic                  sck_rise;
    logic                  sck_fall;
    logic                  cfg_lvl;

    pin_sync #(
        .N (`PIN_COUNT)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .pins_i    ({serial_config_in_i, shift_clk_i, conversion_trigger_i}),
        .level_o   (pin_lvl),
        .rise_o    (pin_rise),
        .fall_o    (pin_fall)
    );

    assign trig_lvl  = pin_lvl[`PIN_TRIG];
    assign trig_rise = pin_rise[`PIN_TRIG];
    assign trig_fall = pin_fall[`PIN_TRIG];
    assign sck_rise  = pin_rise[`PIN_SCK];
    assign sck_fall  = pin_fall[`PIN_SCK];
    assign cfg_lvl   = pin_lvl[`PIN_CFG];

    // =========================================================
    // Result buffer
    stream_if #(.W(RESULT_W)) wr_if ();
    stream_if #(.W(RESULT_W)) rd_if ();

    assign wr_if.valid    = result_valid_i;
    assign wr_if.data     = result_data_i;
    assign result_ready_o = wr_if.ready;

    two_entry_buffer #(
        .W     (RESULT_W),
        .DEPTH (`BUF_DEPTH)
    ) u_buf (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .in_s      (wr_if.sink),
        .out_s     (rd_if.source)
    );

    // =========================================================
    // Conversion sequencer
    ctrl_state_t      state_q;
    ctrl_state_t      state_d;
    logic [CNT_W-1:0] conversion_trigger_cnt_q;
    logic [CNT_W-1:0] conversion_trigger_cnt_d;
    logic             start_q;
    logic             start_d;
    logic             load;

    function automatic logic is_state(input ctrl_state_t s, input ctrl_state_t want);
        return s == want;
    endfunction

    always_comb
    begin
        state_d    = state_q;
        conversion_trigger_cnt_d = conversion_trigger_cnt_q;
        start_d    = 1'b0;
        case (state_q)
            ST_IDLE, ST_SLEEP:
                if (trig_fall)
                begin
                    state_d = ST_TRANSFER;
                end
            ST_CONVERT:
                if (conversion_trigger_cnt_q == '0)
                begin
                    state_d = trig_lvl ? ST_SLEEP : ST_TRANSFER;
                end
                else
                begin
                    conversion_trigger_cnt_d = conversion_trigger_cnt_q - 1'b1;
                end
            ST_TRANSFER:
                state_d = ST_TRANSFER;
            default:
                state_d = ST_IDLE;
        endcase
        if (trig_rise && !is_state(state_q, ST_CONVERT))
        begin
            state_d    = ST_CONVERT;
            conversion_trigger_cnt_d = CONVERSION_TRIGGER_LOAD;
            start_d    = 1'b1;
        end
    end

    assign load        = is_state(state_d, ST_TRANSFER) && !is_state(state_q, ST_TRANSFER);
    assign rd_if.ready = load;

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q    <= ST_IDLE;
            conversion_trigger_cnt_q <= '0;
            start_q    <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            conversion_trigger_cnt_q <= conversion_trigger_cnt_d;
            start_q    <= start_d;
        end
    end

    assign conversion_trigger_start_o = start_q;
    assign sleep_o      = is_state(state_q, ST_SLEEP);

    // =========================================================
    // Result shifter
    logic [RESULT_W-1:0] shreg_q;
    logic [RESULT_W-1:0] shreg_d;
    logic [SH_W-1:0]     shcnt_q;
    logic [SH_W-1:0]     shcnt_d;
    logic                oe_n_q;
    logic                oe_n_d;

    always_comb
    begin
        shreg_d = shreg_q;
        shcnt_d = shcnt_q;
        oe_n_d  = oe_n_q;
        if (trig_rise)
        begin
            oe_n_d = 1'b1;
        end
        if (load)
        begin
            // Empty buffer sends zeros rather than a stale word
            shreg_d = rd_if.valid ? rd_if.data : '0;
            shcnt_d = '0;
            oe_n_d  = 1'b0;
        end
        else if (is_state(state_q, ST_TRANSFER) && sck_fall)
        begin
            shreg_d = {shreg_q[RESULT_W-2:0], 1'b0};
            if (shcnt_q != SH_FULL)
            begin
                shcnt_d = shcnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            shreg_q <= '0;
            shcnt_q <= '0;
            oe_n_q  <= 1'b1;
        end
        else
        begin
            shreg_q <= shreg_d;
            shcnt_q <= shcnt_d;
            oe_n_q  <= oe_n_d;
        end
    end

    assign serial_result_out_o  = shreg_q[RESULT_W-1];
    assign serial_result_oe_n_o = oe_n_q;

    // =========================================================
    // Configuration capture
    logic [`CFG_BITS-1:0] cfg_sh_q;
    logic [`CFG_BITS-1:0] cfg_sh_d;
    logic [1:0]           cfg_cnt_q;
    logic [1:0]           cfg_cnt_d;
    logic [`CFG_BITS-1:0] mux_q;
    logic [`CFG_BITS-1:0] mux_d;

    always_comb
    begin
        cfg_sh_d  = cfg_sh_q;
        cfg_cnt_d = cfg_cnt_q;
        mux_d     = mux_q;
        if (load)
        begin
            cfg_cnt_d = '0;
        end
        else if (TWO_CHANNEL && is_state(state_q, ST_TRANSFER) && sck_rise && cfg_cnt_q != CFG_FULL)
        begin
            cfg_sh_d  = {cfg_sh_q[0], cfg_lvl};
            cfg_cnt_d = cfg_cnt_q + 1'b1;
        end
        if (start_d && cfg_cnt_q == CFG_FULL)
        begin
            mux_d = cfg_sh_q;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cfg_sh_q  <= '0;
            cfg_cnt_q <= '0;
            mux_q     <= `CFG_RESET;
        end
        else
        begin
            cfg_sh_q  <= cfg_sh_d;
            cfg_cnt_q <= cfg_cnt_d;
            mux_q     <= mux_d;
        end
    end

    assign single_or_differential_select_o = mux_q[1];
    assign odd_or_sign_o                   = mux_q[0];

    // =========================================================
    // Checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    conversion_trigger_start_a: assert property (
        trig_rise && state_q != ST_CONVERT |=> state_q == ST_CONVERT && conversion_trigger_start_o)
        else $error("conversion did not start on trigger rise");

    conversion_trigger_time_a: assert property (
        $rose(state_q == ST_CONVERT) |-> ##[1:CONVERSION_TRIGGER_BOUND] state_q != ST_CONVERT)
        else $error("conversion ran past its time");

    sleep_entry_a: assert property (
        state_q == ST_CONVERT && conversion_trigger_cnt_q == '0 && trig_lvl && !trig_fall |=> sleep_o)
        else $error("no sleep with trigger held high");

    oe_enable_a: assert property (
        trig_fall && (state_q == ST_IDLE || state_q == ST_SLEEP) |=> !serial_result_oe_n_o)
        else $error("output not enabled after trigger fall");

    oe_release_a: assert property (
        trig_rise |=> serial_result_oe_n_o)
        else $error("output not released on trigger rise");

    first_bit_a: assert property (
        load && rd_if.valid |=> serial_result_out_o == $past(rd_if.data[RESULT_W-1]))
        else $error("first bit is not the result msb");

    shift_bit_a: assert property (
        state_q == ST_TRANSFER && sck_fall && !load |=> serial_result_out_o == $past(shreg_q[RESULT_W-2]))
        else $error("wrong bit after falling shift clock");

    hold_bit_a: assert property (
        state_q == ST_TRANSFER && state_d == ST_TRANSFER && !sck_fall |=> $stable(serial_result_out_o))
        else $error("output changed without a falling shift clock");

    zero_tail_a: assert property (
        state_q == ST_TRANSFER && shcnt_q == SH_FULL |-> !serial_result_out_o)
        else $error("nonzero bit after full result");

    cfg_ignore_a: assert property (
        cfg_cnt_q == CFG_FULL && !load |=> $stable(cfg_sh_q))
        else $error("configuration changed after two bits");

    cfg_apply_a: assert property (
        start_d && cfg_cnt_q == CFG_FULL |=> mux_q == $past(cfg_sh_q))
        else $error("configuration word not applied");

endmodule

//--- hdl/pin_sync.sv
// Two-stage synchroniser with edge detection for pin inputs
`timescale 1ns/10ps
module pin_sync
#(
    parameter int N = 3
)(
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    input  wire logic [N-1:0] pins_i,
    output logic      [N-1:0] level_o,
    output logic      [N-1:0] rise_o,
    output logic      [N-1:0] fall_o
);

    logic [N-1:0] meta_q;
    logic [N-1:0] sync_q;
    logic [N-1:0] prev_q;

    if (N < 1)
    begin : g_chk
        $error("pin_sync needs at least one pin");
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end
        else
        begin
            meta_q <= pins_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_o = sync_q;
    assign rise_o  = sync_q & ~prev_q;
    assign fall_o  = ~sync_q & prev_q;

endmodule

//--- hdl/stream_if.sv
// Valid and ready word stream between internal modules
`timescale 1ns/10ps
interface stream_if
#(
    parameter int W = 16
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface

//--- hdl/two_entry_buffer.sv
// Small FIFO of flip-flops between converter result and shifter
`timescale 1ns/10ps
module two_entry_buffer
#(
    parameter int W     = 16,
    parameter int DEPTH = 2
)(
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    stream_if.sink    in_s,
    stream_if.source  out_s
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PTR_W:0] FULL = (PTR_W + 1)'(DEPTH);

    logic [W-1:0]     mem_q [DEPTH];
    logic [W-1:0]     mem_d [DEPTH];
    logic [PTR_W-1:0] wr_q;
    logic [PTR_W-1:0] wr_d;
    logic [PTR_W-1:0] rd_q;
    logic [PTR_W-1:0] rd_d;
    logic [PTR_W:0]   cnt_q;
    logic [PTR_W:0]   cnt_d;
    logic             push;
    logic             pop;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_chk
        $error("two_entry_buffer depth must be a power of two, at least 2");
    end

    assign in_s.ready  = (cnt_q != FULL);
    assign out_s.valid = (cnt_q != '0);
    assign out_s.data  = mem_q[rd_q];
    assign push        = in_s.valid && in_s.ready;
    assign pop         = out_s.valid && out_s.ready;

    always_comb
    begin
        mem_d = mem_q;
        wr_d  = wr_q;
        rd_d  = rd_q;
        cnt_d = cnt_q;
        if (push)
        begin
            mem_d[wr_q] = in_s.data;
            wr_d        = wr_q + 1'b1;
        end
        if (pop)
        begin
            rd_d = rd_q + 1'b1;
        end
        if (push && !pop)
        begin
            cnt_d = cnt_q + 1'b1;
        end
        else if (pop && !push)
        begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    for (genvar i = 0; i < DEPTH; i++)
    begin : g_mem
        always_ff @(posedge ref_clk_i or posedge rst_i)
        begin
            if (rst_i)
            begin
                mem_q[i] <= '0;
            end
            else
            begin
                mem_q[i] <= mem_d[i];
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

endmodule

//--- testbench/adc_host_model.sv
// Host controller model driving trigger, shift clock and configuration pins
`timescale 1ns/10ps
module adc_host_model
#(
    parameter real HALF_NS = 62.5
)(
    output logic      conversion_trigger_o,
    output logic      shift_clk_o,
    output logic      serial_config_o,
    input  wire logic serial_result_i
);
    realtime rise_t;

    initial
    begin
        conversion_trigger_o = 1'b0;
        shift_clk_o          = 1'b0;
        serial_config_o      = 1'b0;
        rise_t               = 0.0;
    end

    // =========================================
    // Conversion start
    task automatic start_conversion_trigger();
        conversion_trigger_o = 1'b1;
        rise_t               = $realtime;
    endtask

    // =========================================
    // One transfer of n shift clocks, bits captured on rising edges
    task automatic transfer(input logic [1:0] cfg, input int n, output logic [31:0] got);
        int i;
        got = '0;
        // Trigger high for a full conversion, cycle rate kept low
        if ($realtime < rise_t + 3400.0)
            #(rise_t + 3400.0 - $realtime);
        conversion_trigger_o = 1'b0;
        // Odd offset keeps every shift edge off the sampling clock edge
        #101;
        for (i = 0; i < n; i++)
        begin
            serial_config_o = (i < 2) ? cfg[1-i] : 1'($urandom);
            #HALF_NS shift_clk_o = 1'b1;
            got = {got[30:0], serial_result_i};
            #HALF_NS shift_clk_o = 1'b0;
        end
        // Released line shows the inverse of its last value
        serial_config_o = ~serial_config_o;
        #100;
    endtask
endmodule

//--- testbench/sampling_adc_serial_control_bench.sv
// Self-checking bench of the serial conversion control block
`timescale 1ns/10ps
module sampling_adc_serial_control_bench;
    import adc_ctrl_pkg::*;

    logic        ref_clk;
    logic        rst;
    logic        trig;
    logic        sck;
    logic        cfg_pin;
    logic        sdo_bit;
    logic        sdo_oe_n;
    logic        conversion_trigger_start;
    logic        sleep;
    logic        sel;
    logic        odd;
    logic        res_valid;
    logic [15:0] res_data;
    logic        res_ready;
    wire         sdo_pin = sdo_oe_n ? 1'bz : sdo_bit;
    int          errors;
    int          num_checks;
    int          starts;
    logic [1:0]  cur_cfg;
    logic [15:0] exp_q[$];

    adc_serial_ctrl #(.RESULT_W(16)) dut_u
    (
        .ref_clk_i                       (ref_clk),
        .rst_i                           (rst),
        .conversion_trigger_i            (trig),
        .shift_clk_i                     (sck),
        .serial_config_in_i              (cfg_pin),
        .serial_result_out_o             (sdo_bit),
        .serial_result_oe_n_o            (sdo_oe_n),
        .conversion_trigger_start_o                    (conversion_trigger_start),
        .sleep_o                         (sleep),
        .single_or_differential_select_o (sel),
        .odd_or_sign_o                   (odd),
        .result_valid_i                  (res_valid),
        .result_data_i                   (res_data),
        .result_ready_o                  (res_ready)
    );

    adc_host_model host_u
    (
        .conversion_trigger_o (trig),
        .shift_clk_o          (sck),
        .serial_config_o      (cfg_pin),
        .serial_result_i      (sdo_pin)
    );

    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    always @(negedge ref_clk)
        if (conversion_trigger_start === 1'b1)
            starts++;

    // =========================================
    // Compare and report
    task automatic check_bit(input logic got, input logic exp, input string msg);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %b expected %b", $time, msg, got, exp);
        end
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // =========================================
    // Converter word stream, held until taken
    task automatic push(input logic [15:0] w);
        int k;
        k = 0;
        @(negedge ref_clk);
        res_valid = 1'b1;
        res_data  = w;
        // Ready read off the edge; the next rising edge takes the word
        while (res_ready !== 1'b1 && k < 5000)
        begin
            @(negedge ref_clk);
            k++;
        end
        if (k >= 5000)
        begin
            errors++;
            $display("CHECK FAILED at %0t: converter word never taken", $time);
        end
        @(negedge ref_clk);
        res_valid = 1'b0;
        res_data  = ~w;
        exp_q.push_back(w);
    endtask

    function automatic logic [31:0] expect_word(input logic [15:0] w, input int n);
        return {16'h0000, w} << (n - 16);
    endfunction

    // =========================================
    // One full conversion and transfer cycle
    task automatic run_frame(input logic [1:0] cfg, input int n);
        int          s;
        logic [31:0] got;
        logic [15:0] w;
        @(negedge ref_clk);
        s = starts;
        host_u.start_conversion_trigger();
        #200;
        check_bit(sdo_oe_n, 1'b1, "output enabled during conversion");
        check_word(32'(starts - s), 32'h0000_0001, "conversion starts");
        check_word({30'h0, sel, odd}, {30'h0, cur_cfg}, "mux select");
        check_bit(sleep, 1'b0, "asleep while converting");
        #3200;
        check_bit(sleep, 1'b1, "not asleep after conversion");
        fork
            host_u.transfer(cfg, n, got);
            begin
                #3300;
                check_bit(sleep, 1'b0, "asleep during transfer");
                check_bit(sdo_oe_n, 1'b0, "output off during transfer");
            end
        join
        w = (exp_q.size() > 0) ? exp_q.pop_front() : 16'h0000;
        check_word(got, expect_word(w, n), "serial result");
        cur_cfg = cfg;
    endtask

    initial
    begin
        #300000;
        errors++;
        end_of_test();
    end

    initial
    begin
        rst        = 1'b1;
        res_valid  = 1'b0;
        res_data   = 16'h0000;
        errors     = 0;
        num_checks = 0;
        starts     = 0;
        cur_cfg    = 2'h2;
        void'($urandom(32'h4ea0_8ad6));
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        repeat (5) @(negedge ref_clk);
        // Corner words and an empty buffer with trailing zeros
        push(16'hffff);
        run_frame(2'($urandom), 16);
        push(16'h8001);
        run_frame(2'($urandom), 20);
        run_frame(2'($urandom), 20);
        // Fill until refused, third word waits for a pop
        push(16'($urandom));
        push(16'($urandom));
        @(negedge ref_clk);
        check_bit(res_ready, 1'b0, "buffer full");
        fork
            push(16'($urandom));
            run_frame(2'($urandom), 16);
        join
        run_frame(2'($urandom), 16);
        run_frame(2'($urandom), 18);
        // Every configuration code
        for (int c = 0; c < 4; c++)
        begin
            push(16'($urandom));
            run_frame(2'(c), 16);
        end
        run_frame(2'h2, 16);
        end_of_test();
    end
endmodule
